// ### src/cond_branch_map.svh
// Opcode patterns, field positions and constants for the branch and break unit
`ifndef COND_BRANCH_MAP_SVH
`define COND_BRANCH_MAP_SVH

`define OP_MSB            31
`define OP_LSB            26
`define FS_MSB            25
`define FS_LSB            21
`define SS_MSB            20
`define SS_LSB            16
`define OFF_MSB           15
`define FUNC_MSB          5
`define OP_SPECIAL        6'h00
`define OP_REG_IMM_GROUP  6'h01
`define OP_BR_NE          6'h05
`define OP_BR_NE_LIKELY   6'h15
`define SUB_NEG_LIKELY    5'h02
`define SUB_NEG_LINK      5'h10
`define SUB_NEG_LINK_LKLY 5'h12
`define FUNC_BREAK        6'h0d
`define LINK_REG          5'h1f
`define LINK_STEP         32'h0000_0008
`define SLOT_STEP         32'h0000_0004

`endif

// ### src/cond_branch_pkg.sv
// Types shared by the branch and break unit
package cond_branch_pkg;

    typedef enum logic [5:0]
    {
        op_none                       = 6'h00,
        op_branch_neg_and_link        = 6'h01,
        op_branch_neg_and_link_likely = 6'h02,
        op_branch_neg_likely          = 6'h04,
        op_branch_not_equal           = 6'h08,
        op_branch_not_equal_likely    = 6'h10,
        op_breakpoint                 = 6'h20
    } op_kind_t;

    typedef enum logic [2:0]
    {
        st_idle = 3'b001,
        st_slot = 3'b010,
        st_trap = 3'b100
    } slot_state_t;

endpackage

// ### src/insn_field_decoder.sv
// Instruction word decoder for the branch and break group
`timescale 1ns/1ps
`include "cond_branch_map.svh"

module insn_field_decoder
    import cond_branch_pkg::*;
(
    input  wire logic [31:0] insn_i,
    input  wire logic        level2_en_i,
    output op_kind_t         kind_o,
    output logic             reserved_o,
    output logic [4:0]       first_source_field_o,
    output logic [4:0]       second_source_field_o,
    output logic [15:0]      offset_o
);

    logic [5:0] opc;
    logic [4:0] sub;
    logic [5:0] fn;

    assign opc                   = insn_i[`OP_MSB:`OP_LSB];
    assign sub                   = insn_i[`SS_MSB:`SS_LSB];
    assign fn                    = insn_i[`FUNC_MSB:0];
    assign first_source_field_o  = insn_i[`FS_MSB:`FS_LSB];
    assign second_source_field_o = sub;
    assign offset_o              = insn_i[`OFF_MSB:0];

    always_comb
    begin
        kind_o     = op_none;
        reserved_o = 1'b0;
        if (opc == `OP_REG_IMM_GROUP && sub == `SUB_NEG_LINK)
        begin
            kind_o = op_branch_neg_and_link;
        end
        else if (opc == `OP_REG_IMM_GROUP && sub == `SUB_NEG_LINK_LKLY)
        begin
            kind_o = op_branch_neg_and_link_likely;
        end
        else if (opc == `OP_REG_IMM_GROUP && sub == `SUB_NEG_LIKELY)
        begin
            kind_o = op_branch_neg_likely;
        end
        else if (opc == `OP_BR_NE)
        begin
            kind_o = op_branch_not_equal;
        end
        else if (opc == `OP_BR_NE_LIKELY)
        begin
            kind_o = op_branch_not_equal_likely;
        end
        else if (opc == `OP_SPECIAL && fn == `FUNC_BREAK)
        begin
            kind_o = op_breakpoint;
        end
        // Likely forms without second level support
        if (!level2_en_i && (kind_o == op_branch_neg_and_link_likely ||
            kind_o == op_branch_neg_likely || kind_o == op_branch_not_equal_likely))
        begin
            kind_o     = op_none;
            reserved_o = 1'b1;
        end
    end

endmodule

// ### src/cond_branch_link_break_unit.sv
// Execute logic for conditional branches with link and the breakpoint trap
`timescale 1ns/1ps
`include "cond_branch_map.svh"

module cond_branch_link_break_unit
    import cond_branch_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        insn_valid_i,
    input  wire logic [31:0] insn_i,
    input  wire logic [31:0] insn_pc_i,
    input  wire logic [31:0] first_source_data_i,
    input  wire logic [31:0] second_source_data_i,
    input  wire logic        level2_en_i,
    input  wire logic        slot_exception_i,
    output logic [4:0]       first_source_field_o,
    output logic [4:0]       second_source_field_o,
    output logic             link_we_o,
    output logic [4:0]       link_addr_o,
    output logic [31:0]      link_data_o,
    output logic             redirect_o,
    output logic [31:0]      redirect_pc_o,
    output logic             nullify_slot_o,
    output logic             in_delay_slot_o,
    output logic             breakpoint_exc_o,
    output logic             reserved_exc_o,
    output logic [31:0]      exc_pc_o,
    output logic             exc_in_slot_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    op_kind_t    kind;
    logic        reserved;
    logic [4:0]  fs_field;
    logic [4:0]  ss_field;
    logic [15:0] offset;

    insn_field_decoder u_dec
    (
        .insn_i                (insn_i),
        .level2_en_i           (level2_en_i),
        .kind_o                (kind),
        .reserved_o            (reserved),
        .first_source_field_o  (fs_field),
        .second_source_field_o (ss_field),
        .offset_o              (offset)
    );

    assign first_source_field_o  = fs_field;
    assign second_source_field_o = ss_field;

    function automatic logic [31:0] branch_target(input logic [31:0] pc,
                                                 input logic [15:0] off);
        logic [31:0] ext;
        ext = {{14{off[15]}}, off, 2'b00};
        return pc + `SLOT_STEP + ext;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Condition

    logic is_link;
    logic is_likely;
    logic is_branch;
    logic cond;
    logic issue;

    assign is_link   = (kind == op_branch_neg_and_link) ||
                       (kind == op_branch_neg_and_link_likely);
    assign is_likely = (kind == op_branch_neg_and_link_likely) ||
                       (kind == op_branch_neg_likely) ||
                       (kind == op_branch_not_equal_likely);
    assign is_branch = (kind != op_none) && (kind != op_breakpoint);

    always_comb
    begin
        if (kind == op_branch_not_equal || kind == op_branch_not_equal_likely)
        begin
            cond = (first_source_data_i != second_source_data_i);
        end
        else
        begin
            cond = first_source_data_i[31];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay slot sequencing

    slot_state_t state_r;
    slot_state_t state_nxt;
    logic        taken_r;
    logic        likely_r;
    logic [31:0] target_r;
    logic [31:0] branch_pc_r;

    // Only accept new instructions in the idle state, not in a pending slot or the trap cycle
    assign issue = insn_valid_i && (state_r == st_idle);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            st_idle:
            begin
                if (issue && kind == op_breakpoint)
                begin
                    state_nxt = st_trap;
                end
                else if (issue && is_branch)
                begin
                    state_nxt = st_slot;
                end
            end
            st_slot:
            begin
                if (insn_valid_i || slot_exception_i)
                begin
                    state_nxt = st_idle;
                end
            end
            st_trap:
            begin
                state_nxt = st_idle;
            end
            default:
            begin
                state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r <= st_idle;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            taken_r     <= 1'b0;
            likely_r    <= 1'b0;
            target_r    <= 32'h0000_0000;
            branch_pc_r <= 32'h0000_0000;
        end
        else if (issue && is_branch)
        begin
            taken_r     <= cond;
            likely_r    <= is_likely;
            target_r    <= branch_target(insn_pc_i, offset);
            branch_pc_r <= insn_pc_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link write

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            link_we_o   <= 1'b0;
            link_addr_o <= 5'h00;
            link_data_o <= 32'h0000_0000;
        end
        else
        begin
            link_we_o   <= issue && is_link;
            link_addr_o <= `LINK_REG;
            link_data_o <= insn_pc_i + `LINK_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Redirect and nullify at the delay slot

    logic slot_done;

    assign slot_done = (state_r == st_slot) && insn_valid_i && !slot_exception_i;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            redirect_o      <= 1'b0;
            redirect_pc_o   <= 32'h0000_0000;
            nullify_slot_o  <= 1'b0;
            in_delay_slot_o <= 1'b0;
        end
        else
        begin
            redirect_o      <= slot_done && taken_r;
            redirect_pc_o   <= target_r;
            nullify_slot_o  <= slot_done && likely_r && !taken_r;
            in_delay_slot_o <= (state_nxt == st_slot);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exceptions

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            breakpoint_exc_o <= 1'b0;
            reserved_exc_o   <= 1'b0;
            exc_pc_o         <= 32'h0000_0000;
            exc_in_slot_o    <= 1'b0;
        end
        else
        begin
            // No code field is carried on any exception output
            breakpoint_exc_o <= issue && (kind == op_breakpoint);
            reserved_exc_o   <= issue && reserved;
            exc_in_slot_o    <= (state_r == st_slot) && slot_exception_i;
            if ((state_r == st_slot) && slot_exception_i)
            begin
                exc_pc_o <= branch_pc_r;
            end
            else if (issue)
            begin
                exc_pc_o <= insn_pc_i;
            end
        end
    end

endmodule

// ### tb/branch_unit_chk.sv
// Port checks for the branch and break unit
`timescale 1ns/1ps

module branch_unit_chk
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        insn_valid_i,
    input wire logic [31:0] insn_i,
    input wire logic [31:0] insn_pc_i,
    input wire logic        level2_en_i,
    input wire logic        link_we_o,
    input wire logic [4:0]  link_addr_o,
    input wire logic [31:0] link_data_o,
    input wire logic        redirect_o,
    input wire logic [31:0] redirect_pc_o,
    input wire logic        nullify_slot_o,
    input wire logic        in_delay_slot_o,
    input wire logic        breakpoint_exc_o,
    input wire logic        reserved_exc_o,
    input wire logic [31:0] exc_pc_o,
    input wire logic        exc_in_slot_o
);
    wire logic       take = insn_valid_i && !in_delay_slot_o && !breakpoint_exc_o;
    wire logic [5:0] op   = insn_i[31:26];
    wire logic [4:0] sub  = insn_i[20:16];

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    chk_link_dest:
    assert property (link_we_o |-> link_addr_o == 5'h1f && link_data_o == $past(insn_pc_i) + 32'h8)
        else $error("link write wrong");
    chk_link_issue:
    assert property (take && op == 6'h01 && sub == 5'h10 |=> link_we_o && in_delay_slot_o)
        else $error("link branch not issued");
    chk_brk_trap:
    assert property (take && op == 6'h00 && insn_i[5:0] == 6'h0d
        |=> breakpoint_exc_o && exc_pc_o == $past(insn_pc_i))
        else $error("breakpoint not raised");
    chk_reserved_gate:
    assert property (take && !level2_en_i &&
        (op == 6'h15 || op == 6'h01 && (sub == 5'h12 || sub == 5'h02))
        |=> reserved_exc_o && !link_we_o && !in_delay_slot_o)
        else $error("likely form not reserved");
    chk_target_calc:
    assert property (redirect_o |-> redirect_pc_o == $past(insn_pc_i, 2) + 32'h4
        + {{14{$past(insn_i[15], 2)}}, $past(insn_i[15:0], 2), 2'b00})
        else $error("branch target wrong");
    chk_redirect_end:
    assert property (redirect_o |-> !nullify_slot_o && !in_delay_slot_o && $past(in_delay_slot_o))
        else $error("redirect out of place");
    chk_nullify_end:
    assert property (nullify_slot_o |-> $past(in_delay_slot_o) && !redirect_o)
        else $error("nullify out of place");
    chk_slot_restart:
    assert property (exc_in_slot_o |-> !redirect_o && exc_pc_o == $past(insn_pc_i, 2))
        else $error("slot restart pc wrong");
endmodule

bind cond_branch_link_break_unit branch_unit_chk branch_unit_chk_inst
(
    .clk_i(clk_i), .reset_i(reset_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
    .insn_pc_i(insn_pc_i), .level2_en_i(level2_en_i), .link_we_o(link_we_o),
    .link_addr_o(link_addr_o), .link_data_o(link_data_o), .redirect_o(redirect_o),
    .redirect_pc_o(redirect_pc_o), .nullify_slot_o(nullify_slot_o),
    .in_delay_slot_o(in_delay_slot_o), .breakpoint_exc_o(breakpoint_exc_o),
    .reserved_exc_o(reserved_exc_o), .exc_pc_o(exc_pc_o), .exc_in_slot_o(exc_in_slot_o)
);

// ### tb/reg_file_model.sv
// Register file model feeding the source operands
`timescale 1ns/1ps

module reg_file_model
(
    input  wire logic        clk_i,
    input  wire logic [4:0]  rd_a_i,
    input  wire logic [4:0]  rd_b_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  wa_i,
    input  wire logic [31:0] wd_i,
    output logic [31:0]      rd_a_o,
    output logic [31:0]      rd_b_o
);
    logic [31:0] regs [32];

    // Register zero reads as zero
    assign rd_a_o = (rd_a_i == 5'h00) ? 32'h0 : regs[rd_a_i];
    assign rd_b_o = (rd_b_i == 5'h00) ? 32'h0 : regs[rd_b_i];

    always @(posedge clk_i)
    begin
        if (we_i)
        begin
            regs[wa_i] <= wd_i;
        end
    end
endmodule

// ### tb/tb_cond_branch_link_break_unit.sv
// Self-checking bench for the branch and break unit
`timescale 1ns/1ps
`include "cond_branch_map.svh"

module tb_cond_branch_link_break_unit;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        insn_valid_i = 1'b0;
    logic [31:0] insn_i = 32'h0;
    logic [31:0] insn_pc_i = 32'h0;
    logic        level2_en_i = 1'b0;
    logic        slot_exception_i = 1'b0;
    logic [31:0] rs_d, rt_d, link_data_o, redirect_pc_o, exc_pc_o;
    logic [4:0]  rs_f, rt_f, link_addr_o;
    logic        link_we_o, redirect_o, nullify_slot_o, in_delay_slot_o;
    logic        breakpoint_exc_o, reserved_exc_o, exc_in_slot_o;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;

    cond_branch_link_break_unit cond_branch_link_break_unit_inst
    (
        .clk_i(clk_i), .reset_i(reset_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
        .insn_pc_i(insn_pc_i), .first_source_data_i(rs_d), .second_source_data_i(rt_d),
        .level2_en_i(level2_en_i), .slot_exception_i(slot_exception_i),
        .first_source_field_o(rs_f), .second_source_field_o(rt_f), .link_we_o(link_we_o),
        .link_addr_o(link_addr_o), .link_data_o(link_data_o), .redirect_o(redirect_o),
        .redirect_pc_o(redirect_pc_o), .nullify_slot_o(nullify_slot_o),
        .in_delay_slot_o(in_delay_slot_o), .breakpoint_exc_o(breakpoint_exc_o),
        .reserved_exc_o(reserved_exc_o), .exc_pc_o(exc_pc_o), .exc_in_slot_o(exc_in_slot_o)
    );

    reg_file_model reg_file_model_inst
    (
        .clk_i(clk_i), .rd_a_i(rs_f), .rd_b_i(rt_f), .we_i(link_we_o), .wa_i(link_addr_o),
        .wd_i(link_data_o), .rd_a_o(rs_d), .rd_b_o(rt_d)
    );

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ri(input logic [4:0] rs, sub, input logic [15:0] off);
        return {`OP_REG_IMM_GROUP, rs, sub, off};
    endfunction

    task automatic step;
        @(posedge clk_i);
        #2;
    endtask

    // Branch, then its delay slot, then settle; fl is link, redirect, nullify, slot exception
    task automatic branch(input logic [31:0] w, pc, tgt, input logic [3:0] fl);
        insn_valid_i = 1'b1;
        insn_i = w;
        insn_pc_i = pc;
        step();
        insn_i = 32'h0;
        insn_pc_i = pc + 32'h4;
        slot_exception_i = fl[0];
        cmp_bit(link_we_o, fl[3]);
        cmp_word(fl[3] ? link_data_o : {27'h0, link_addr_o},
                 fl[3] ? pc + 32'h8 : 32'h0000_001f);
        cmp_bit(in_delay_slot_o, 1'b1);
        step();
        insn_valid_i = 1'b0;
        slot_exception_i = 1'b0;
        cmp_bit(redirect_o, fl[2]);
        cmp_bit(nullify_slot_o, fl[1]);
        cmp_bit(exc_in_slot_o, fl[0]);
        cmp_word(fl[2] ? redirect_pc_o : {31'h0, in_delay_slot_o},
                 fl[2] ? tgt : 32'h0);
        cmp_word(fl[0] ? exc_pc_o : {31'h0, exc_in_slot_o},
                 fl[0] ? pc : 32'h0);
        step();
    endtask

    task automatic t_neg_link;
        reg_file_model_inst.regs[4] = 32'h8000_0000;
        reg_file_model_inst.regs[5] = 32'h7fff_ffff;
        branch(ri(5'h04, `SUB_NEG_LINK, 16'hfffe), 32'h100, 32'hfc, 4'b1100);
        branch(ri(5'h05, `SUB_NEG_LINK, 16'h0010), 32'h200, 32'h0, 4'b1000);
        branch(ri(5'h04, `SUB_NEG_LINK, 16'h0010), 32'h600, 32'h0, 4'b1001);
    endtask

    task automatic t_likely;
        level2_en_i = 1'b1;
        reg_file_model_inst.regs[7] = 32'h1234_5678;
        reg_file_model_inst.regs[8] = 32'h1234_5678;
        branch(ri(5'h05, `SUB_NEG_LINK_LKLY, 16'h0004), 32'h300, 32'h0, 4'b1010);
        branch(ri(5'h04, `SUB_NEG_LIKELY, 16'h7fff), 32'h300, 32'h20300, 4'b0100);
        branch({`OP_BR_NE_LIKELY, 10'h0e8, 16'h0001}, 32'h400, 32'h0, 4'b0010);
        branch({`OP_BR_NE_LIKELY, 10'h085, 16'h0001}, 32'h400, 32'h408, 4'b0100);
        level2_en_i = 1'b0;
    endtask

    task automatic t_not_equal;
        reg_file_model_inst.regs[9] = 32'h1234_5679;
        branch({`OP_BR_NE, 10'h0e9, 16'h8000}, 32'h10_0000, 32'he_0004, 4'b0100);
        branch({`OP_BR_NE, 10'h0e8, 16'h8000}, 32'h10_0000, 32'h0, 4'b0000);
    endtask

    task automatic t_trap;
        insn_valid_i = 1'b1;
        insn_i = {`OP_SPECIAL, 20'habcde, `FUNC_BREAK};
        insn_pc_i = 32'h500;
        step();
        insn_i = ri(5'h04, `SUB_NEG_LINK, 16'h0001);
        cmp_bit(breakpoint_exc_o, 1'b1);
        cmp_word(exc_pc_o, 32'h500);
        step();
        insn_i = {`OP_BR_NE_LIKELY, 10'h0e9, 16'h0001};
        cmp_bit(link_we_o, 1'b0);
        cmp_bit(breakpoint_exc_o, 1'b0);
        step();
        insn_i = ri(5'h04, `SUB_NEG_LINK_LKLY, 16'h0001);
        cmp_bit(reserved_exc_o, 1'b1);
        cmp_bit(in_delay_slot_o, 1'b0);
        step();
        insn_valid_i = 1'b0;
        cmp_bit(reserved_exc_o, 1'b1);
        cmp_bit(link_we_o, 1'b0);
        step();
    endtask

    task automatic test_done;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 500)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // No scenario names register 31 as a link source
    initial
    begin
        repeat (4) @(posedge clk_i);
        #2;
        reset_i = 1'b0;
        t_neg_link();
        t_likely();
        t_not_equal();
        t_trap();
        test_done();
    end
endmodule
